/* File: include/ams_regs.vh */
`ifndef AMS_REGS_VH
`define AMS_REGS_VH
// ==========================================
// register map (byte addresses)
`define AMS_OFF_CTRL 8'h00
`define AMS_OFF_STATION 8'h04
`define AMS_OFF_DIVISOR 8'h08
`define AMS_OFF_STATUS 8'h0c
// ==========================================
// fields and reset values
`define AMS_CTRL_AUTO 0
`define AMS_CTRL_DEDIC 1
`define AMS_CTRL_RESET 2'h1
`define AMS_STATION_RESET 8'h10
`define AMS_STATION_ODD 8'h01
`define AMS_DIV_RESET 20'h6ef91
`define AMS_PIN_RESET 4'h1
`define AMS_RESP_OKAY 2'h0
`define AMS_RESP_DECERR 2'h3
// ==========================================
// control commands, low nibble of the byte
`define AMS_CMD_RTS_ON 4'h1
`define AMS_CMD_RTS_OFF 4'h2
`define AMS_CMD_ALLOW 4'h3
`define AMS_CMD_INHIBIT 4'h4
// ==========================================
// framing and timing
`define AMS_LAST_DATA_BIT 3'h7
`define AMS_TX_UNITS_AFTER_START 4'ha
`define AMS_CLK_KHZ 50000
`define AMS_ANSWER_MS 8000
`define AMS_HANGUP_MS 1000
`endif

/* File: verilog/ams_buffer.v */
`timescale 1ns/1ps
`default_nettype none
`include "ams_regs.vh"

module ams_buffer #(
  parameter [31:0] ANSWER_CYCLES = `AMS_ANSWER_MS * `AMS_CLK_KHZ,
  parameter [31:0] HANGUP_CYCLES = `AMS_HANGUP_MS * `AMS_CLK_KHZ
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] device_select,
  input wire control_output_instruction,
  input wire data_input_instruction,
  input wire data_output_instruction,
  input wire address_input_instruction,
  input wire [7:0] bus_data_in,
  output wire [7:0] bus_data_out,
  output wire bus_data_oe,
  output wire bus_ack,
  output wire rx_service_req,
  output wire tx_service_req,
  input wire rx_serial_in,
  input wire cts_in,
  input wire carrier_in,
  input wire ring_in,
  output wire tx_serial_out,
  output wire rts_out,
  output wire dtr_out
);

  // ==========================================
  // state encodings
  localparam [3:0] RX_IDLE = 4'h1;
  localparam [3:0] RX_START = 4'h2;
  localparam [3:0] RX_DATA = 4'h4;
  localparam [3:0] RX_STOP = 4'h8;
  localparam [1:0] TX_IDLE = 2'h1;
  localparam [1:0] TX_SEND = 2'h2;
  localparam [3:0] CALL_IDLE = 4'h1;
  localparam [3:0] CALL_ANSWER = 4'h2;
  localparam [3:0] CALL_DATA = 4'h4;
  localparam [3:0] CALL_HANGUP = 4'h8;

  reg [1:0] ctrl_reg;
  reg [7:0] station_reg;
  reg [19:0] div_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [3:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  reg [3:0] rx_state_reg;
  reg [19:0] rx_tick_reg;
  reg [2:0] rx_bit_reg;
  reg [7:0] rx_shift_reg, rx_hold_reg;
  reg rx_done_reg, rx_valid_reg, rx_flag_reg;
  reg [1:0] tx_state_reg;
  reg [19:0] tx_tick_reg;
  reg [3:0] tx_cnt_reg;
  reg [9:0] tx_shift_reg;
  reg tx_out_reg, tx_done_reg, tx_flag_reg;
  reg rx_allow_reg, tx_allow_reg, rts_reg;
  reg [3:0] call_state_reg;
  reg [31:0] call_cnt_reg;
  reg call_up_reg;
  reg bus_ack_reg, bus_oe_reg;
  reg [7:0] bus_data_reg;

  // ==========================================
  // pin synchronisers
  wire [3:0] pin_raw = {ring_in, carrier_in, cts_in, rx_serial_in};
  wire rx_line = pin_reg[0];
  wire cts_line = pin_reg[1];
  wire carrier_line = pin_reg[2];
  wire ring_line = pin_reg[3];

  // three stages, a change counts when stages two and three agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= `AMS_PIN_RESET;
      sync2_reg <= `AMS_PIN_RESET;
      sync3_reg <= `AMS_PIN_RESET;
      pin_reg <= `AMS_PIN_RESET;
    end
    else
    begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
    end
  end

  // ==========================================
  // register slave
  wire dedicated = ctrl_reg[`AMS_CTRL_DEDIC];
  wire auto_answer = ctrl_reg[`AMS_CTRL_AUTO];
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  wire rd_go = s_axi_arvalid & ~rvalid_reg;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] ctrl_merge = ({30'h0, ctrl_reg} & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] stat_merge = ({24'h0, station_reg} & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] div_merge = ({12'h0, div_reg} & ~wmask) | (s_axi_wdata & wmask);
  wire [7:0] station_new = stat_merge[7:0] & ~`AMS_STATION_ODD;
  wire wr_map = (s_axi_awaddr == `AMS_OFF_CTRL) | (s_axi_awaddr == `AMS_OFF_STATION) |
                (s_axi_awaddr == `AMS_OFF_DIVISOR) | (s_axi_awaddr == `AMS_OFF_STATUS);
  wire [31:0] status_word = {19'h0, call_state_reg, carrier_line, cts_line, rts_reg,
                             tx_allow_reg, rx_allow_reg, tx_state_reg[1], tx_flag_reg,
                             rx_flag_reg, rx_valid_reg};

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // writes to configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `AMS_CTRL_RESET;
      station_reg <= `AMS_STATION_RESET;
      div_reg <= `AMS_DIV_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= `AMS_RESP_OKAY;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `AMS_RESP_OKAY : `AMS_RESP_DECERR;
        if (s_axi_awaddr == `AMS_OFF_CTRL)
          ctrl_reg <= ctrl_merge[1:0];
        if (s_axi_awaddr == `AMS_OFF_STATION && station_new != 8'h00)
          station_reg <= station_new;
        if (s_axi_awaddr == `AMS_OFF_DIVISOR)
          div_reg <= div_merge[19:0];
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // read data mux
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `AMS_RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else if (rd_go)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `AMS_RESP_OKAY;
      case (s_axi_araddr)
        `AMS_OFF_CTRL: rdata_reg <= {30'h0, ctrl_reg};
        `AMS_OFF_STATION: rdata_reg <= {24'h0, station_reg};
        `AMS_OFF_DIVISOR: rdata_reg <= {12'h0, div_reg};
        `AMS_OFF_STATUS: rdata_reg <= status_word;
        default:
        begin
          rdata_reg <= 32'h0;
          rresp_reg <= `AMS_RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ==========================================
  // host instruction decode
  wire [7:0] tx_addr = station_reg & ~`AMS_STATION_ODD;
  wire [7:0] rx_addr = station_reg | `AMS_STATION_ODD;
  wire rx_hit = device_select == rx_addr;
  wire tx_hit = device_select == tx_addr;
  wire rx_req = rx_flag_reg & rx_allow_reg;
  wire tx_req = tx_flag_reg & tx_allow_reg;
  wire tx_clear = ~dedicated | (rts_reg & cts_line);
  wire din_take = data_input_instruction & rx_hit & rx_valid_reg;
  wire dout_take = data_output_instruction & tx_hit & tx_state_reg[0] & tx_clear;
  wire ain_rx = address_input_instruction & rx_req;
  wire ain_tx = address_input_instruction & ~rx_req & tx_req;
  wire ctrl_take = control_output_instruction & (rx_hit | tx_hit);
  wire [3:0] cmd = bus_data_in[3:0];

  assign bus_ack = bus_ack_reg;
  assign bus_data_oe = bus_oe_reg;
  assign bus_data_out = bus_data_reg;
  assign rx_service_req = rx_req;
  assign tx_service_req = tx_req;
  assign rts_out = rts_reg;
  assign tx_serial_out = tx_out_reg;

  // answer on the bus one cycle after the strobe
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bus_ack_reg <= 1'b0;
      bus_oe_reg <= 1'b0;
      bus_data_reg <= 8'h00;
    end
    else
    begin
      bus_ack_reg <= din_take | dout_take | ctrl_take;
      bus_oe_reg <= din_take | ain_rx | ain_tx;
      if (din_take)
        bus_data_reg <= rx_hold_reg;
      else if (ain_rx)
        bus_data_reg <= rx_addr;
      else if (ain_tx)
        bus_data_reg <= tx_addr;
      else
        bus_data_reg <= 8'h00;
    end
  end

  // section command flags
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_allow_reg <= 1'b0;
      tx_allow_reg <= 1'b0;
      rts_reg <= 1'b0;
    end
    else if (ctrl_take)
    begin
      if (cmd == `AMS_CMD_INHIBIT)
      begin
        rx_allow_reg <= rx_hit ? 1'b0 : rx_allow_reg;
        tx_allow_reg <= tx_hit ? 1'b0 : tx_allow_reg;
      end
      if (cmd == `AMS_CMD_ALLOW)
      begin
        rx_allow_reg <= rx_hit ? 1'b1 : rx_allow_reg;
        tx_allow_reg <= tx_hit ? 1'b1 : tx_allow_reg;
      end
      if (cmd == `AMS_CMD_RTS_ON && rx_hit)
        rts_reg <= 1'b1;
      if (cmd == `AMS_CMD_RTS_OFF && rx_hit)
        rts_reg <= 1'b0;
    end
  end

  // pending requests, a new event beats the clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_valid_reg <= 1'b0;
      rx_flag_reg <= 1'b0;
      tx_flag_reg <= 1'b0;
    end
    else
    begin
      if (rx_done_reg)
      begin
        rx_valid_reg <= 1'b1;
        rx_flag_reg <= 1'b1;
      end
      else
      begin
        rx_valid_reg <= rx_valid_reg & ~din_take;
        rx_flag_reg <= rx_flag_reg & ~din_take & ~ain_rx;
      end
      if (tx_done_reg | call_up_reg)
        tx_flag_reg <= 1'b1;
      else
        tx_flag_reg <= tx_flag_reg & ~dout_take & ~ain_tx;
    end
  end

  // ==========================================
  // receiver
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 20'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_hold_reg <= 8'h00;
      rx_done_reg <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (rx_tick_reg != 20'h0 && !rx_state_reg[0])
        rx_tick_reg <= rx_tick_reg - 20'h1;
      case (rx_state_reg)
        RX_IDLE:
        begin
          if (!rx_line)
          begin
            rx_tick_reg <= {1'b0, div_reg[19:1]};
            rx_state_reg <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_tick_reg == 20'h0)
          begin
            rx_tick_reg <= div_reg - 20'h1;
            rx_bit_reg <= 3'h0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_tick_reg == 20'h0)
          begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_tick_reg <= div_reg - 20'h1;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == `AMS_LAST_DATA_BIT)
              rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (rx_tick_reg == 20'h0)
          begin
            rx_state_reg <= RX_IDLE;
            if (rx_line)
            begin
              rx_hold_reg <= rx_shift_reg;
              rx_done_reg <= 1'b1;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // ==========================================
  // transmitter
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= 20'h0;
      tx_cnt_reg <= 4'h0;
      tx_shift_reg <= 10'h3ff;
      tx_out_reg <= 1'b1;
      tx_done_reg <= 1'b0;
    end
    else
    begin
      tx_done_reg <= 1'b0;
      case (tx_state_reg)
        TX_IDLE:
        begin
          tx_out_reg <= 1'b1;
          if (dout_take)
          begin
            tx_out_reg <= 1'b0;
            tx_shift_reg <= {2'h3, bus_data_in};
            tx_cnt_reg <= `AMS_TX_UNITS_AFTER_START;
            tx_tick_reg <= div_reg - 20'h1;
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tx_tick_reg != 20'h0)
            tx_tick_reg <= tx_tick_reg - 20'h1;
          else if (tx_cnt_reg == 4'h0)
          begin
            tx_state_reg <= TX_IDLE;
            tx_done_reg <= 1'b1;
          end
          else
          begin
            tx_out_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            tx_tick_reg <= div_reg - 20'h1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ==========================================
  // call control
  assign dtr_out = dedicated | call_state_reg[1] | call_state_reg[2];

  // answer, hold and end switched calls
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      call_state_reg <= CALL_IDLE;
      call_cnt_reg <= 32'h0;
      call_up_reg <= 1'b0;
    end
    else
    begin
      call_up_reg <= 1'b0;
      if (call_cnt_reg != 32'h0)
        call_cnt_reg <= call_cnt_reg - 32'h1;
      case (call_state_reg)
        CALL_IDLE:
        begin
          if (ring_line && auto_answer && !dedicated)
          begin
            call_state_reg <= CALL_ANSWER;
            call_cnt_reg <= ANSWER_CYCLES;
          end
        end
        CALL_ANSWER:
        begin
          if (carrier_line)
          begin
            call_state_reg <= CALL_DATA;
            call_up_reg <= 1'b1;
          end
          else if (call_cnt_reg == 32'h0)
          begin
            call_state_reg <= CALL_HANGUP;
            call_cnt_reg <= HANGUP_CYCLES;
          end
        end
        CALL_DATA:
        begin
          if (!carrier_line)
          begin
            call_state_reg <= CALL_HANGUP;
            call_cnt_reg <= HANGUP_CYCLES;
          end
        end
        CALL_HANGUP:
        begin
          if (call_cnt_reg == 32'h0)
            call_state_reg <= CALL_IDLE;
        end
        default: call_state_reg <= CALL_IDLE;
      endcase
    end
  end

endmodule // ams_buffer
`default_nettype wire

/* File: verif/ams_buffer_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ams_regs.vh"
// =====
// host bus and line checker
module ams_buffer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] device_select,
  input wire logic control_output_instruction,
  input wire logic data_input_instruction,
  input wire logic data_output_instruction,
  input wire logic address_input_instruction,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic bus_ack,
  input wire logic rx_service_req,
  input wire logic tx_service_req,
  input wire logic tx_serial_out,
  input wire logic rts_out
);
  localparam [7:0] TXA = `AMS_STATION_RESET;
  localparam [7:0] RXA = `AMS_STATION_RESET | `AMS_STATION_ODD;
  // address match and strobe groups
  wire tx_hit = device_select == TXA;
  wire rx_hit = device_select == RXA;
  wire [3:0] cmd = bus_data_in[3:0];
  wire ack_src = control_output_instruction | data_input_instruction | data_output_instruction;
  wire oe_src = data_input_instruction | address_input_instruction;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_ctrl_ack: assert property (control_output_instruction && (tx_hit || rx_hit) |=> bus_ack)
    else $error("control not acknowledged");
  a_no_match: assert property (ack_src && !tx_hit && !rx_hit |=> !bus_ack)
    else $error("acknowledge on foreign address");
  a_ack_cause: assert property (bus_ack |-> $past(ack_src))
    else $error("acknowledge without strobe");
  a_oe_cause: assert property (bus_data_oe |-> $past(oe_src))
    else $error("bus driven without input strobe");
  a_ain_rx: assert property (address_input_instruction && rx_service_req
    |=> bus_data_oe && bus_data_out == RXA && !bus_ack)
    else $error("address input wrong");
  a_din_clear: assert property (data_input_instruction && rx_hit && rx_service_req
    |=> bus_ack && bus_data_oe && !rx_service_req)
    else $error("data input not served");
  a_rts_on: assert property (control_output_instruction && rx_hit && cmd == `AMS_CMD_RTS_ON
    |=> ##[0:1] rts_out)
    else $error("request to send not raised");
  a_rts_off: assert property (control_output_instruction && rx_hit && cmd == `AMS_CMD_RTS_OFF
    |=> ##[0:1] !rts_out)
    else $error("request to send not dropped");
  a_tx_inhibit: assert property (control_output_instruction && tx_hit
    && cmd == `AMS_CMD_INHIBIT |=> !tx_service_req)
    else $error("inhibit ignored");
  a_start_ack: assert property (bus_ack
    && $past(data_output_instruction && tx_hit && !control_output_instruction)
    |-> !tx_serial_out)
    else $error("accepted byte without start bit");
  a_reset_state: assert property ($rose(aresetn)
    |-> !rts_out && !rx_service_req && !tx_service_req && tx_serial_out)
    else $error("reset state wrong");
endmodule // ams_buffer_chk
bind ams_buffer ams_buffer_chk u_chk (.aclk, .aresetn, .device_select,
  .control_output_instruction, .data_input_instruction, .data_output_instruction,
  .address_input_instruction, .bus_data_in, .bus_data_out, .bus_data_oe, .bus_ack,
  .rx_service_req, .tx_service_req, .tx_serial_out, .rts_out);
`default_nettype wire

/* File: verif/ams_data_set.sv */
`timescale 1ns/1ps
`default_nettype none
// =====
// data set model: loopback, clear-to-send, answer carrier
module ams_data_set #(
  parameter int CTS_DLY = 30
) (
  input wire logic aclk,
  input wire logic tx_serial_out,
  input wire logic rts_out,
  input wire logic dtr_out,
  input wire logic answer_en,
  output wire logic rx_serial_in,
  output logic cts_in = 1'b0,
  output logic carrier_in = 1'b0
);
  int cts_cnt = 0;
  int car_cnt = 0;
  // local loop, line rests at mark between characters
  assign rx_serial_in = tx_serial_out;
  // remote end answers after a set-up delay
  always @(posedge aclk)
  begin
    cts_cnt <= rts_out ? cts_cnt + 1 : 0;
    car_cnt <= (dtr_out && answer_en) ? car_cnt + 1 : 0;
    cts_in <= rts_out && cts_cnt >= CTS_DLY;
    carrier_in <= car_cnt >= 10;
  end
endmodule // ams_data_set
`default_nettype wire

/* File: verif/test_async_modem_serial_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ams_regs.vh"
`define CHK(n, e, a) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
    end \
  end
`define WAITC(c, lim) \
  for (n = 0; n < (lim); n++) \
  begin \
    @(negedge aclk); \
    if (c) \
      break; \
  end \
  if (n >= (lim)) \
    hang(); \
  @(posedge aclk);
// =====
// bench top
module test_async_modem_serial_buffer;
  localparam [7:0] TXA = 8'h10;
  localparam [7:0] RXA = 8'h11;
  localparam [31:0] DIV = 32'd8;
  localparam int CO = 0, DI = 1, DO = 2, AI = 3;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0] device_select = 8'h00, bus_data_in = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0, st = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ring_in = 0, ans = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire bus_data_oe, bus_ack, rx_service_req, tx_service_req, rx_serial_in;
  wire cts_in, carrier_in, tx_serial_out, rts_out, dtr_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] bus_data_out;
  int bad_count = 0;
  int samples_checked = 0;
  // clock
  always #10 aclk = ~aclk;
  ams_buffer #(.ANSWER_CYCLES(32'd200), .HANGUP_CYCLES(32'd50)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .device_select, .control_output_instruction(st[0]),
    .data_input_instruction(st[1]), .data_output_instruction(st[2]),
    .address_input_instruction(st[3]), .bus_data_in, .bus_data_out, .bus_data_oe,
    .bus_ack, .rx_service_req, .tx_service_req, .rx_serial_in, .cts_in, .carrier_in,
    .ring_in, .tx_serial_out, .rts_out, .dtr_out);
  ams_data_set u_set (.aclk, .tx_serial_out, .rts_out, .dtr_out, .answer_en(ans),
    .rx_serial_in, .cts_in, .carrier_in);
  // =====
  // verdict and bus tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    bad_count++;
    $display("wait timed out");
    summarize();
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    `WAITC(s_axi_awready, 100)
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    `WAITC(s_axi_bvalid, 100)
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    `WAITC(s_axi_arready, 100)
    s_axi_arvalid <= 1'b0;
    `WAITC(s_axi_rvalid, 100)
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  // one host instruction pulse, answer settled on return
  task automatic io(input int k, input [7:0] s, input [7:0] d);
    @(posedge aclk);
    device_select <= s;
    bus_data_in <= d;
    st <= 4'h1 << k;
    @(posedge aclk);
    st <= 4'h0;
    #1;
  endtask
  // =====
  // scenarios
  task automatic t_reset;
    `CHK("rts", 1'b0, rts_out)
    `CHK("reqs", 2'b00, {rx_service_req, tx_service_req})
    `CHK("txd idle", 1'b1, tx_serial_out)
    rd(`AMS_OFF_STATION, 32'h10, `AMS_RESP_OKAY);
    rd(8'h40, 32'h0, `AMS_RESP_DECERR);
    wr(8'h40, 32'h1, `AMS_RESP_DECERR);
    wr(`AMS_OFF_DIVISOR, DIV, `AMS_RESP_OKAY);
    rd(`AMS_OFF_DIVISOR, DIV, `AMS_RESP_OKAY);
    $display("t_reset done");
  endtask
  task automatic t_ctrl;
    io(CO, 8'h12, `AMS_CMD_ALLOW);
    `CHK("foreign ack", 1'b0, bus_ack)
    for (int c = 1; c <= 4; c++)
    begin
      io(CO, TXA, c[7:0]);
      `CHK("ctl ack", 1'b1, bus_ack)
      `CHK("rts tx", 1'b0, rts_out)
    end
    io(CO, RXA, `AMS_CMD_INHIBIT);
    `CHK("rx inh ack", 1'b1, bus_ack)
    `CHK("txreq", 1'b0, tx_service_req)
    $display("t_ctrl done");
  endtask
  task automatic t_frame;
    logic [7:0] b;
    b = 8'h4b;
    io(DO, TXA, b);
    `CHK("dout ack", 1'b1, bus_ack)
    `CHK("start", 1'b0, tx_serial_out)
    io(DO, TXA, 8'hff);
    `CHK("busy ack", 1'b0, bus_ack)
    repeat (2) @(posedge aclk);
    `CHK("start mid", 1'b0, tx_serial_out)
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(posedge aclk);
      `CHK("bit", b[i], tx_serial_out)
    end
    repeat (DIV) @(posedge aclk);
    `CHK("stop1", 1'b1, tx_serial_out)
    repeat (DIV) @(posedge aclk);
    `CHK("stop2", 1'b1, tx_serial_out)
    repeat (2 * DIV) @(posedge aclk);
    `CHK("inhibited", 2'b00, {rx_service_req, tx_service_req})
    rd(`AMS_OFF_STATUS, 32'h207, `AMS_RESP_OKAY);
    io(CO, RXA, `AMS_CMD_ALLOW);
    `CHK("rxreq", 1'b1, rx_service_req)
    io(AI, 8'h00, 8'h00);
    `CHK("ain rx", {1'b1, 1'b0, RXA}, {bus_data_oe, bus_ack, bus_data_out})
    `CHK("rxreq clr", 1'b0, rx_service_req)
    io(CO, TXA, `AMS_CMD_ALLOW);
    `CHK("txreq", 1'b1, tx_service_req)
    io(AI, 8'h00, 8'h00);
    `CHK("ain tx", {1'b1, TXA}, {bus_data_oe, bus_data_out})
    `CHK("txreq clr", 1'b0, tx_service_req)
    io(DI, RXA, 8'h00);
    `CHK("din", {2'b11, b}, {bus_ack, bus_data_oe, bus_data_out})
    io(DI, RXA, 8'h00);
    `CHK("din empty", {2'b00, 8'h00}, {bus_ack, bus_data_oe, bus_data_out})
    $display("t_frame done");
  endtask
  task automatic t_call;
    int n;
    `CHK("txreq idle", 1'b0, tx_service_req)
    ans <= 1'b1;
    ring_in <= 1'b1;
    `WAITC(dtr_out, 20)
    `CHK("answer", 1'b1, dtr_out)
    ring_in <= 1'b0;
    `WAITC(tx_service_req, 60)
    `CHK("channel up", 1'b1, tx_service_req)
    io(CO, TXA, `AMS_CMD_INHIBIT);
    `CHK("txreq inh", 1'b0, tx_service_req)
    io(CO, TXA, `AMS_CMD_ALLOW);
    `CHK("txreq kept", 1'b1, tx_service_req)
    ans <= 1'b0;
    `WAITC(!dtr_out, 20)
    `CHK("hang up", 1'b0, dtr_out)
    repeat (80) @(posedge aclk);
    ring_in <= 1'b1;
    repeat (10) @(posedge aclk);
    ring_in <= 1'b0;
    `CHK("wrong call", 1'b1, dtr_out)
    repeat (150) @(posedge aclk);
    `CHK("still answering", 1'b1, dtr_out)
    `WAITC(!dtr_out, 80)
    `CHK("dropped", 1'b0, dtr_out)
    repeat (60) @(posedge aclk);
    $display("t_call done");
  endtask
  task automatic t_dedic;
    wr(`AMS_OFF_CTRL, 32'h2, `AMS_RESP_OKAY);
    io(DO, TXA, 8'h5a);
    `CHK("no rts ack", 1'b0, bus_ack)
    io(CO, RXA, `AMS_CMD_RTS_ON);
    @(posedge aclk);
    `CHK("rts on", 1'b1, rts_out)
    io(DO, TXA, 8'h5a);
    `CHK("no cts ack", 1'b0, bus_ack)
    repeat (40) @(posedge aclk);
    io(DO, TXA, 8'h5a);
    `CHK("cts ack", 1'b1, bus_ack)
    repeat (12 * DIV) @(posedge aclk);
    io(CO, RXA, `AMS_CMD_RTS_OFF);
    @(posedge aclk);
    `CHK("rts off", 1'b0, rts_out)
    wr(`AMS_OFF_CTRL, 32'h1, `AMS_RESP_OKAY);
    $display("t_dedic done");
  endtask
  // main sequence, with a reset in mid-run at the end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_frame();
    t_call();
    t_dedic();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK("rst reqs", 3'b000, {rx_service_req, tx_service_req, rts_out})
    summarize();
  end
endmodule // test_async_modem_serial_buffer
`default_nettype wire
